// File: lcc_pkg.sv
// Package: shared constants and carrier types for the logic cluster control
package lcc_pkg;
  localparam int LCC_CELLS = 10;
  localparam int LCC_ROW_CLKS = 8;
  localparam int LCC_LOCAL_W = 16;
  localparam int LCC_REACH = 30;
  localparam int LCC_CTRL_MAX = 10;
  localparam int LCC_SEL_W = 3;
  localparam logic LCC_CLEAR_VAL = 1'h0;
  localparam logic LCC_PRESET_VAL = 1'h1;
  localparam logic LCC_SUB_CIN = 1'h1;

  // Per-cell configuration
  typedef struct packed {
    logic [15:0] lutMask;
    logic useChainIn;
    logic regChainIn;
    logic clkSel;
    logic clrSel;
    logic bypassReg;
    logic arith;
  } lcc_cell_cfg_t;

  // Cluster-wide control selection
  typedef struct packed {
    logic [LCC_SEL_W-1:0] clkSrcA;
    logic [LCC_SEL_W-1:0] clkSrcB;
    logic invertB;
    logic [3:0] enaIdx;
    logic [3:0] clrAIdx;
    logic [3:0] clrBIdx;
    logic [3:0] aloadIdx;
    logic [3:0] sclrIdx;
    logic [3:0] sloadIdx;
    logic [3:0] addSubIdx;
  } lcc_ctrl_cfg_t;

  // Derived cluster-wide controls
  typedef struct packed {
    logic clockA;
    logic clockB;
    logic gateA;
    logic gateB;
    logic clearA;
    logic clearB;
    logic asyncLoad;
    logic syncClear;
    logic syncLoad;
    logic addSub;
  } lcc_ctrl_t;
endpackage : lcc_pkg

// File: lcc_logic_cluster.sv
// Logic cluster: control generator, ten cells, chains and local routing
`timescale 1ns/100ps
// Overview of operation
// - Cluster holds ten logic cells with carry, lookup, register chains.
// - Lookup output of each cell feeds the next cell directly.
// - Registered output of each cell can shift into next register.
// - Local routing links cells; each reaches thirty other cells.
// - Local routing takes row/column, own outputs, left/right neighbours.
// - Generator gives two clocks, enables, clears, and four more controls.
// - Each cluster clock is always paired with its own enable.
// - Using both edges of one clock occupies both cluster clocks.
// - Low enable stops its clock; its registers take no synchronous update.
// - Async load with data high presets registers to one.
// - Sync clear and load work for any register at the edge.
// - Add/subtract select switches each cell dynamically.
// - Controls derive from eight row clocks and local routing.
// - Subtract inverts second operand and forces first carry-in to one.
// - Sync clear and load hit each cluster register at its own clock's tick.
module lcc_logic_cluster
  import lcc_pkg::*;
#(
  parameter int CELLS = LCC_CELLS,
  parameter int ROWS = LCC_ROW_CLKS,
  parameter int LOCALW = LCC_LOCAL_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Row clocks and routing inputs from the fabric
  input wire logic [ROWS-1:0] rowClk,
  input wire logic [LOCALW-1:0] rowColIn,
  input wire logic [CELLS-1:0] leftLink,
  input wire logic [CELLS-1:0] rightLink,
  // Configuration
  input wire lcc_ctrl_cfg_t ctrlCfg,
  input wire lcc_cell_cfg_t [CELLS-1:0] cellCfg,
  input wire logic [CELLS-1:0][1:0] opSel,
  // Cluster carry
  input wire logic carryIn,
  output logic carryOut,
  // Cell and control outputs
  output logic [CELLS-1:0] cellOut,
  output logic [CELLS-1:0] regOut,
  output logic [CELLS-1:0] leftLinkOut,
  output logic [CELLS-1:0] rightLinkOut,
  output lcc_ctrl_t ctrlOut
);
  localparam int SRCW = LOCALW + 2 * CELLS + CELLS;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Row clocks and routing arrive from outside mclk's domain
  logic [ROWS-1:0] rowS1_r, rowS2_r;
  logic [LOCALW-1:0] rcS1_r, rcS2_r;
  logic [CELLS-1:0] lS1_r, lS2_r, rS1_r, rS2_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rowS1_r <= '0;
      rowS2_r <= '0;
      rcS1_r <= '0;
      rcS2_r <= '0;
      lS1_r <= '0;
      lS2_r <= '0;
      rS1_r <= '0;
      rS2_r <= '0;
    end else begin
      rowS1_r <= rowClk;
      rowS2_r <= rowS1_r;
      rcS1_r <= rowColIn;
      rcS2_r <= rcS1_r;
      lS1_r <= leftLink;
      lS2_r <= lS1_r;
      rS1_r <= rightLink;
      rS2_r <= rS1_r;
    end
  end

  // ------------------------------------------------------------
  // Local routing
  // ------------------------------------------------------------
  // Own outputs, row/column and both neighbours share one pool
  logic [CELLS-1:0] lutOut;
  logic [CELLS-1:0] q_r;
  wire [SRCW-1:0] localPool = {q_r, lS2_r, rS2_r, rcS2_r};
  wire [LOCALW-1:0] ctrlPool = rcS2_r;

  // ------------------------------------------------------------
  // Control generator
  // ------------------------------------------------------------
  // Clocks come from the row clocks, the rest from routing
  lcc_ctrl_t ctrl;
  wire rowA = rowS2_r[ctrlCfg.clkSrcA];
  wire rowB = rowS2_r[ctrlCfg.clkSrcB];
  wire enaA = ctrlPool[ctrlCfg.enaIdx];
  // Clock B on the same row but opposite sense gives the falling edge
  wire dualEdge = (ctrlCfg.clkSrcA == ctrlCfg.clkSrcB) && ctrlCfg.invertB;
  assign ctrl.clockA = rowA;
  assign ctrl.clockB = ctrlCfg.invertB ? ~rowB : rowB;
  assign ctrl.gateA = enaA;
  assign ctrl.gateB = ctrlPool[ctrlCfg.enaIdx + 4'h1];
  assign ctrl.clearA = ctrlPool[ctrlCfg.clrAIdx];
  assign ctrl.clearB = ctrlPool[ctrlCfg.clrBIdx];
  assign ctrl.asyncLoad = ctrlPool[ctrlCfg.aloadIdx];
  assign ctrl.syncClear = ctrlPool[ctrlCfg.sclrIdx];
  assign ctrl.syncLoad = ctrlPool[ctrlCfg.sloadIdx];
  assign ctrl.addSub = ctrlPool[ctrlCfg.addSubIdx];

  // Edge detect on sampled clocks; stage two is past the synchroniser
  logic clkAPrev_r, clkBPrev_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clkAPrev_r <= 1'h0;
      clkBPrev_r <= 1'h0;
    end else begin
      clkAPrev_r <= ctrl.clockA;
      clkBPrev_r <= ctrl.clockB;
    end
  end
  // An enable gates only its own clock
  wire tickA = ctrl.clockA & ~clkAPrev_r & ctrl.gateA;
  wire tickB = ctrl.clockB & ~clkBPrev_r & ctrl.gateB;

  // ------------------------------------------------------------
  // Cells: lookup chain, carry chain, register chain
  // ------------------------------------------------------------
  logic [CELLS:0] carry;
  // Subtract forces the first carry to one
  assign carry[0] = ctrl.addSub ? LCC_SUB_CIN : carryIn;
  logic [CELLS-1:0] dIn;
  logic [CELLS-1:0] tick;
  logic [CELLS-1:0] aclr;

  for (genvar i = 0; i < CELLS; i++) begin : gCell
    wire chainIn = (i == 0) ? 1'h0 : lutOut[(i == 0) ? 0 : i-1];
    wire regPrev = (i == 0) ? 1'h0 : q_r[(i == 0) ? 0 : i-1];
    // Operand A may come from the left neighbour's link of the same cell
    wire a = localPool[opSel[i][0] ? i + LOCALW + CELLS : i];
    wire bRaw = localPool[opSel[i][1] ? (i + CELLS) % SRCW : i + 1];
    // Lookup chain replaces one operand with the previous result
    wire d0 = cellCfg[i].useChainIn ? chainIn : a;
    wire b = ctrl.addSub ? ~bRaw : bRaw;
    wire [3:0] lutIdx = {carry[i], b, bRaw, d0};
    wire lutV = cellCfg[i].lutMask[lutIdx];
    wire sumV = d0 ^ b ^ carry[i];
    assign carry[i+1] = (d0 & b) | (d0 & carry[i]) | (b & carry[i]);
    assign lutOut[i] = cellCfg[i].arith ? sumV : lutV;
    // Register chain enables shift-register use
    assign dIn[i] = cellCfg[i].regChainIn ? regPrev : lutOut[i];
    assign tick[i] = cellCfg[i].clkSel ? tickB : tickA;
    assign aclr[i] = cellCfg[i].clrSel ? ctrl.clearB : ctrl.clearA;
    assign cellOut[i] = cellCfg[i].bypassReg ? lutOut[i] : q_r[i];
  end
  assign carryOut = carry[CELLS];

  // Async preset loads the data3 level; clear dominates
  wire aloadData = rcS2_r[LOCALW-1];

  // Register next value: sync clear beats sync load
  logic [CELLS-1:0] q_nxt;
  always_comb begin
    q_nxt = q_r;
    for (int j = 0; j < CELLS; j++) begin
      if (tick[j]) begin
        if (ctrl.syncClear) begin
          q_nxt[j] = LCC_CLEAR_VAL;
        end else if (ctrl.syncLoad) begin
          q_nxt[j] = localPool[j];
        end else begin
          q_nxt[j] = dIn[j];
        end
      end
      if (ctrl.asyncLoad) begin
        q_nxt[j] = aloadData ? LCC_PRESET_VAL : LCC_CLEAR_VAL;
      end
      if (aclr[j]) begin
        q_nxt[j] = LCC_CLEAR_VAL;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  lcc_ctrl_t ctrl_r;
  logic [CELLS-1:0] lOut_r, rOut_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= '0;
      lOut_r <= '0;
      rOut_r <= '0;
    end else begin
      ctrl_r <= ctrl;
      lOut_r <= cellOut;
      rOut_r <= lutOut;
    end
  end
  assign regOut = q_r;
  assign leftLinkOut = lOut_r;
  assign rightLinkOut = rOut_r;
  assign ctrlOut = ctrl_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence clrSeq(int k);
    aclr[k] ##0 1'b1;
  endsequence

  cell_count_a: assert property (CELLS == LCC_CELLS)
    else $error("cell count wrong");
  ctrl_count_a: assert property ($bits(lcc_ctrl_t) <= LCC_CTRL_MAX)
    else $error("too many controls");
  reach_a: assert property (SRCW >= LCC_REACH)
    else $error("routing reach short");
  gate_hold_a: assert property ((!tickA && !tickB && !ctrl.asyncLoad
      && ctrl.clearA == 1'b0 && ctrl.clearB == 1'b0) |=> q_r == $past(q_r))
    else $error("register moved without clock");
  async_clr_a: assert property (clrSeq(0) |=> !q_r[0])
    else $error("clear did not force zero");
  preset_a: assert property ((ctrl.asyncLoad && aloadData && !aclr[1])
      |=> q_r[1])
    else $error("preset did not force one");
  sclr_pri_a: assert property ((tick[2] && ctrl.syncClear && ctrl.syncLoad
      && !ctrl.asyncLoad && !aclr[2]) |=> !q_r[2])
    else $error("sync clear lost priority");
  shift_a: assert property ((tick[3] && cellCfg[3].regChainIn
      && !ctrl.syncClear && !ctrl.syncLoad && !ctrl.asyncLoad && !aclr[3])
      |=> q_r[3] == $past(q_r[2]))
    else $error("register chain broken");
  lut_chain_a: assert property ((cellCfg[1].useChainIn && !cellCfg[1].arith
      && cellCfg[1].lutMask == 16'haaaa) |-> lutOut[1] == lutOut[0])
    else $error("lookup chain broken");
  sub_cin_a: assert property (ctrl.addSub |-> carry[0])
    else $error("subtract carry not one");
  dual_edge_a: assert property (dualEdge |-> ctrl.clockB == !ctrl.clockA)
    else $error("dual edge pairing wrong");
endmodule : lcc_logic_cluster

// File: lcc_fabric_model.sv
// Row clock network and local routing model facing the logic cluster
`timescale 1ns/100ps
module lcc_fabric_model
  import lcc_pkg::*;
#(
  parameter int HOLD = 4
) (
  // Clock
  input wire logic mclk,
  // Fabric outputs
  output logic [LCC_ROW_CLKS-1:0] rowClk,
  output logic [LCC_LOCAL_W-1:0] rowColIn
);
  initial begin
    rowClk = '0;
    rowColIn = '0;
  end

  // New routing level, then let the two sync stages settle
  task automatic route(input logic [LCC_LOCAL_W-1:0] val);
    @(posedge mclk);
    #1 rowColIn = val;
    repeat (HOLD) @(posedge mclk);
  endtask : route

  // Both phases last HOLD cycles; the edge detect needs each phase sampled on at least one mclk edge
  task automatic pulse(input int row);
    @(posedge mclk);
    #1 rowClk[row] = 1'h1;
    repeat (HOLD) @(posedge mclk);
    #1 rowClk[row] = 1'h0;
    repeat (HOLD) @(posedge mclk);
  endtask : pulse
endmodule : lcc_fabric_model

// File: test_logic_cluster_control.sv
// Self-checking bench for the logic cluster control block
`timescale 1ns/100ps
module test_logic_cluster_control
  import lcc_pkg::*;
;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] rowClk;
  logic [15:0] rowColIn;
  lcc_ctrl_cfg_t ctrlCfg;
  lcc_cell_cfg_t [9:0] cellCfg;
  logic [9:0] regOut;
  lcc_ctrl_t ctrlOut;
  logic [9:0] leftLink;
  logic [9:0] rightLink;
  logic [9:0][1:0] opSel;
  logic carryIn;
  logic carryOut;
  logic [9:0] cellOut;
  logic [9:0] leftLinkOut;
  logic [9:0] rightLinkOut;
  int fails = 0;
  int n_tests = 0;

  always #5 mclk = ~mclk;

  lcc_fabric_model fab (.mclk(mclk), .rowClk(rowClk), .rowColIn(rowColIn));

  lcc_logic_cluster dut (
    .mclk(mclk), .rst_b(rst_b), .rowClk(rowClk), .rowColIn(rowColIn),
    .leftLink(leftLink), .rightLink(rightLink), .ctrlCfg(ctrlCfg),
    .cellCfg(cellCfg), .opSel(opSel), .carryIn(carryIn),
    .carryOut(carryOut), .cellOut(cellOut), .regOut(regOut),
    .leftLinkOut(leftLinkOut), .rightLinkOut(rightLinkOut),
    .ctrlOut(ctrlOut));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Routing bits: 10 enable A, 11 enable B, 9 sync load, 8 sync clear
  task automatic test_gates();
    fab.route(16'h0400);
    check({ctrlOut.gateA, ctrlOut.gateB}, 16'h0002);
    fab.route(16'h0800);
    check({ctrlOut.gateA, ctrlOut.gateB}, 16'h0001);
  endtask : test_gates

  task automatic test_load();
    fab.route(16'h06a5);
    fab.pulse(0);
    check(16'(regOut), 16'h02a5);
  endtask : test_load

  // Enable low must freeze every register despite a row clock tick
  task automatic test_gate_off();
    fab.route(16'h025a);
    fab.pulse(0);
    check(16'(regOut), 16'h02a5);
  endtask : test_gate_off

  // Cell 0 has no upstream register, so only cells 9..1 are judged
  task automatic test_chain();
    #1;
    for (int j = 0; j < 10; j++) begin
      cellCfg[j].regChainIn = 1'h1;
    end
    fab.route(16'h0400);
    fab.pulse(0);
    check(16'(regOut[9:1]), 16'h00a5);
    #1 cellCfg = '0;
  endtask : test_chain

  // Registers hold 0x2a5; cell 9 adds its left and right link operands
  task automatic test_links();
    #1;
    for (int j = 0; j < 10; j++) begin
      cellCfg[j].arith = 1'h1;
    end
    opSel[9] = 2'h3;
    leftLink = 10'h200;
    rightLink = 10'h008;
    carryIn = 1'h1;
    check(16'(cellOut), 16'h02a5);
    check(16'(leftLinkOut), 16'h02a5);
    fab.route(16'h0000);
    check(16'(rightLinkOut), 16'h0001);
    check(16'(carryOut), 16'h0001);
    #1 rightLink = 10'h000;
    fab.route(16'h0000);
    check(16'(rightLinkOut), 16'h0201);
    check(16'(carryOut), 16'h0000);
    // Subtract: 0x080 minus 0x040 with carry-in forced despite carryIn low
    #1 opSel = '0;
    carryIn = 1'h0;
    fab.route(16'h0080);
    check(16'(carryOut), 16'h0001);
    check(16'(rightLinkOut), 16'h0040);
    #1 cellCfg = '0;
    leftLink = 10'h000;
  endtask : test_links

  task automatic test_sync_prio();
    fab.route(16'h07ff);
    fab.pulse(0);
    check(16'(regOut), 16'h0000);
  endtask : test_sync_prio

  // Async controls act with no row clock tick at all
  task automatic test_async();
    fab.route(16'hc000);
    repeat (2) @(posedge mclk);
    check(16'(regOut), 16'h03ff);
    fab.route(16'hd000);
    repeat (2) @(posedge mclk);
    check(16'(regOut), 16'h0000);
    fab.route(16'h0000);
  endtask : test_async

  initial begin
    ctrlCfg = '{clkSrcA: 3'h0, clkSrcB: 3'h1, invertB: 1'h0, enaIdx: 4'ha,
      clrAIdx: 4'hc, clrBIdx: 4'hd, aloadIdx: 4'he, sclrIdx: 4'h8,
      sloadIdx: 4'h9, addSubIdx: 4'h7};
    cellCfg = '0;
    leftLink = 10'h000;
    rightLink = 10'h000;
    opSel = '0;
    carryIn = 1'h0;
    repeat (5) @(posedge mclk);
    #1 rst_b = 1'h1;
    repeat (3) @(posedge mclk);
    check(16'(regOut), 16'h0000);
    check(16'(ctrlOut), 16'h0000);
    test_gates();
    test_load();
    test_gate_off();
    test_chain();
    test_sync_prio();
    test_load();
    test_links();
    test_async();
    report_and_stop();
  end

  // Whole run needs about 120 cycles; this leaves ample margin
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
endmodule : test_logic_cluster_control
